// File: logic/port_fg_defs.vh
// Constants for the port F pad-control and port G I/O block.
`ifndef PORT_FG_DEFS_VH
`define PORT_FG_DEFS_VH

// ==========================================================================
// Register byte offsets.
`define OFS_F_PULLUP    8'h00
`define OFS_F_SLEW      8'h04
`define OFS_F_DRIVE     8'h08
`define OFS_G_DATA      8'h0C
`define OFS_G_DIR       8'h10
`define OFS_F_DIR       8'h14

// ==========================================================================
// Implemented bit masks and reset values.
`define MASK_F          8'h73
`define MASK_G          8'h7F
`define RST_REG         8'h00
`define RST_WORD        32'h0000_0000
`define RST_STRB        4'h0
`define ZERO_PAD        24'h00_0000

// ==========================================================================
// Bus response codes.
`define RESP_OKAY       2'h0
`define RESP_SLVERR     2'h2

// ==========================================================================
// Read channel state codes.
`define ST_RD_IDLE      1'h0
`define ST_RD_RESP      1'h1

// ==========================================================================
// Synchroniser width.
`define G_PINS          7

`endif

// File: logic/sync2.v
// Two flip-flop level synchroniser of parameterised width.
`timescale 1ns/1ps
`default_nettype none

module sync2 #(
    parameter WIDTH = 1
) (
    input  wire             clk_sys_i,
    input  wire             resetn_i,
    input  wire [WIDTH-1:0] async_i,
    output wire [WIDTH-1:0] sync_o
);

    // ======================================================================
    // First stage feeds only the second stage.
    reg [WIDTH-1:0] meta_q;
    reg [WIDTH-1:0] sync_q;

    always @(posedge clk_sys_i or negedge resetn_i) begin
        if (!resetn_i) begin
            meta_q <= {WIDTH{1'b0}};
            sync_q <= {WIDTH{1'b0}};
        end else begin
            meta_q <= async_i;
            sync_q <= meta_q;
        end
    end

    assign sync_o = sync_q;

endmodule // sync2

`default_nettype wire

// File: logic/port_fg_io.v
// Port F pad controls and port G parallel I/O behind an AXI4-Lite slave.
//
// Overview of operation
// - A port F pullup is on when its pullup-enable bit is 1 and off when 0.
// - A port F pin set as output always has its pullup off.
// - A port F pin gets slew limiting when its slew-enable bit is 1, not when 0.
// - The slew-enable bit of a port F pin set as input does nothing.
// - A port F drive bit of 0 picks low drive and 1 picks high drive.
// - Reading port G data gives the pin level for each bit set as input.
// - Reading port G data gives the latched value for each bit set as output.
// - Every port G data write with byte lane 0 strobed updates all latch bits, inputs included.
// - A port G bit set as output drives its latch level onto the pin.
// - Reset clears the port G latch and leaves all pins undriven, pullups off.
// - A port G direction bit of 0 means input and pin readback, 1 output and latch readback.
// - A port F direction bit of 0 means input, undriven, and 1 means output.
`timescale 1ns/1ps
`default_nettype none
`include "port_fg_defs.vh"

module port_fg_io (
    input  wire        clk_sys_i,
    input  wire        resetn_i,

    // AXI4-Lite write address channel.
    input  wire [7:0]  s_axi_awaddr_i,
    input  wire [2:0]  s_axi_awprot_i,
    input  wire        s_axi_awvalid_i,
    output wire        s_axi_awready_o,

    // AXI4-Lite write data channel.
    input  wire [31:0] s_axi_wdata_i,
    input  wire [3:0]  s_axi_wstrb_i,
    input  wire        s_axi_wvalid_i,
    output wire        s_axi_wready_o,

    // AXI4-Lite write response channel.
    output wire [1:0]  s_axi_bresp_o,
    output wire        s_axi_bvalid_o,
    input  wire        s_axi_bready_i,

    // AXI4-Lite read address channel.
    input  wire [7:0]  s_axi_araddr_i,
    input  wire [2:0]  s_axi_arprot_i,
    input  wire        s_axi_arvalid_i,
    output wire        s_axi_arready_o,

    // AXI4-Lite read data channel.
    output wire [31:0] s_axi_rdata_o,
    output wire [1:0]  s_axi_rresp_o,
    output wire        s_axi_rvalid_o,
    input  wire        s_axi_rready_i,

    // Port F pad controls.
    output wire [7:0]  port_f_pullup_on_o,
    output wire [7:0]  port_f_slew_on_o,
    output wire [7:0]  port_f_drive_high_o,
    output wire [7:0]  port_f_dir_o,

    // Port G pins.
    input  wire [6:0]  port_g_pin_i,
    output wire [6:0]  port_g_pin_o,
    output wire [6:0]  port_g_pin_oe_o
);

    // ======================================================================
    // Register state.
    reg [7:0]  f_pullup_q;
    reg [7:0]  f_slew_q;
    reg [7:0]  f_drive_q;
    reg [7:0]  f_dir_q;
    reg [7:0]  g_latch_q;
    reg [7:0]  g_dir_q;

    // ======================================================================
    // Pad output flops.
    reg [7:0]  f_pullup_on_q;
    reg [7:0]  f_slew_on_q;
    reg [7:0]  f_drive_high_q;
    reg [7:0]  f_pullup_on_d;
    reg [7:0]  f_slew_on_d;
    reg [7:0]  f_drive_high_d;

    // ======================================================================
    // Write channel state.
    reg        aw_hold_q;
    reg        aw_hold_d;
    reg [7:0]  aw_addr_q;
    reg        w_hold_q;
    reg        w_hold_d;
    reg [31:0] w_data_q;
    reg [3:0]  w_strb_q;
    reg        awready_q;
    reg        wready_q;
    reg        bvalid_q;
    reg        bvalid_d;
    reg [1:0]  bresp_q;
    reg [1:0]  bresp_d;
    wire       wr_fire;
    reg        wr_hit;

    // ======================================================================
    // Read channel state.
    reg        rd_state_q;
    reg        rd_state_d;
    reg        arready_q;
    reg [31:0] rdata_q;
    reg [31:0] rdata_d;
    reg [1:0]  rresp_q;
    reg [1:0]  rresp_d;
    wire       rd_take;
    reg [7:0]  rd_byte;
    reg        rd_hit;

    // ======================================================================
    // Synchronised port G pin levels.
    wire [6:0] g_pin_sync;
    wire [7:0] g_pin_word;
    wire [7:0] g_readback;

    sync2 #(
        .WIDTH    (`G_PINS)
    ) u_g_sync (
        .clk_sys_i(clk_sys_i),
        .resetn_i (resetn_i),
        .async_i  (port_g_pin_i),
        .sync_o   (g_pin_sync)
    );

    assign g_pin_word = {1'b0, g_pin_sync};

    // Direction picks latch or pin per bit; bit 7 masked to zero.
    assign g_readback = ((g_dir_q & g_latch_q) | (~g_dir_q & g_pin_word)) & `MASK_G;

    // ======================================================================
    // Write address and data capture, in either order.
    assign wr_fire = aw_hold_q & w_hold_q & ~bvalid_q;

    always @* begin
        aw_hold_d = aw_hold_q;
        w_hold_d  = w_hold_q;
        bvalid_d  = bvalid_q;
        bresp_d   = bresp_q;
        if (s_axi_awvalid_i && awready_q) begin
            aw_hold_d = 1'b1;
        end
        if (s_axi_wvalid_i && wready_q) begin
            w_hold_d = 1'b1;
        end
        if (bvalid_q && s_axi_bready_i) begin
            bvalid_d = 1'b0;
        end
        if (wr_fire) begin
            aw_hold_d = 1'b0;
            w_hold_d  = 1'b0;
            bvalid_d  = 1'b1;
            bresp_d   = wr_hit ? `RESP_OKAY : `RESP_SLVERR;
        end
    end

    always @* begin
        case (aw_addr_q)
            `OFS_F_PULLUP: wr_hit = 1'b1;
            `OFS_F_SLEW:   wr_hit = 1'b1;
            `OFS_F_DRIVE:  wr_hit = 1'b1;
            `OFS_G_DATA:   wr_hit = 1'b1;
            `OFS_G_DIR:    wr_hit = 1'b1;
            `OFS_F_DIR:    wr_hit = 1'b1;
            default:       wr_hit = 1'b0;
        endcase
    end

    always @(posedge clk_sys_i or negedge resetn_i) begin
        if (!resetn_i) begin
            aw_hold_q <= 1'b0;
            w_hold_q  <= 1'b0;
            aw_addr_q <= `RST_REG;
            w_data_q  <= `RST_WORD;
            w_strb_q  <= `RST_STRB;
            awready_q <= 1'b0;
            wready_q  <= 1'b0;
            bvalid_q  <= 1'b0;
            bresp_q   <= `RESP_OKAY;
        end else begin
            aw_hold_q <= aw_hold_d;
            w_hold_q  <= w_hold_d;
            bvalid_q  <= bvalid_d;
            bresp_q   <= bresp_d;
            awready_q <= ~aw_hold_d & ~bvalid_d;
            wready_q  <= ~w_hold_d & ~bvalid_d;
            if (s_axi_awvalid_i && awready_q) begin
                aw_addr_q <= s_axi_awaddr_i;
            end
            if (s_axi_wvalid_i && wready_q) begin
                w_data_q <= s_axi_wdata_i;
                w_strb_q <= s_axi_wstrb_i;
            end
        end
    end

    // ======================================================================
    // Register writes; only byte lane 0 carries data.
    always @(posedge clk_sys_i or negedge resetn_i) begin
        if (!resetn_i) begin
            f_pullup_q <= `RST_REG;
            f_slew_q   <= `RST_REG;
            f_drive_q  <= `RST_REG;
            f_dir_q    <= `RST_REG;
            g_latch_q  <= `RST_REG;
            g_dir_q    <= `RST_REG;
        end else if (wr_fire && w_strb_q[0]) begin
            case (aw_addr_q)
                `OFS_F_PULLUP: begin
                    f_pullup_q <= w_data_q[7:0] & `MASK_F;
                end
                `OFS_F_SLEW: begin
                    f_slew_q <= w_data_q[7:0] & `MASK_F;
                end
                `OFS_F_DRIVE: begin
                    f_drive_q <= w_data_q[7:0] & `MASK_F;
                end
                `OFS_G_DATA: begin
                    g_latch_q <= w_data_q[7:0] & `MASK_G;
                end
                `OFS_G_DIR: begin
                    g_dir_q <= w_data_q[7:0] & `MASK_G;
                end
                `OFS_F_DIR: begin
                    f_dir_q <= w_data_q[7:0] & `MASK_F;
                end
                default: begin
                    f_dir_q <= f_dir_q;
                end
            endcase
        end
    end

    // ======================================================================
    // Read channel.
    assign rd_take = s_axi_arvalid_i & arready_q;

    always @* begin
        case (s_axi_araddr_i)
            `OFS_F_PULLUP: begin
                rd_byte = f_pullup_q;
                rd_hit  = 1'b1;
            end
            `OFS_F_SLEW: begin
                rd_byte = f_slew_q;
                rd_hit  = 1'b1;
            end
            `OFS_F_DRIVE: begin
                rd_byte = f_drive_q;
                rd_hit  = 1'b1;
            end
            `OFS_G_DATA: begin
                rd_byte = g_readback;
                rd_hit  = 1'b1;
            end
            `OFS_G_DIR: begin
                rd_byte = g_dir_q;
                rd_hit  = 1'b1;
            end
            `OFS_F_DIR: begin
                rd_byte = f_dir_q;
                rd_hit  = 1'b1;
            end
            default: begin
                rd_byte = `RST_REG;
                rd_hit  = 1'b0;
            end
        endcase
    end

    always @* begin
        rd_state_d = rd_state_q;
        rdata_d    = rdata_q;
        rresp_d    = rresp_q;
        case (rd_state_q)
            `ST_RD_IDLE: begin
                if (rd_take) begin
                    rd_state_d = `ST_RD_RESP;
                    rdata_d    = {`ZERO_PAD, rd_byte};
                    rresp_d    = rd_hit ? `RESP_OKAY : `RESP_SLVERR;
                end
            end
            `ST_RD_RESP: begin
                if (s_axi_rready_i) begin
                    rd_state_d = `ST_RD_IDLE;
                end
            end
            default: begin
                rd_state_d = `ST_RD_IDLE;
            end
        endcase
    end

    always @(posedge clk_sys_i or negedge resetn_i) begin
        if (!resetn_i) begin
            rd_state_q <= `ST_RD_IDLE;
            arready_q  <= 1'b0;
            rdata_q    <= `RST_WORD;
            rresp_q    <= `RESP_OKAY;
        end else begin
            rd_state_q <= rd_state_d;
            arready_q  <= (rd_state_d == `ST_RD_IDLE);
            rdata_q    <= rdata_d;
            rresp_q    <= rresp_d;
        end
    end

    // ======================================================================
    // Port F pad control outputs.
    always @* begin
        f_pullup_on_d  = f_pullup_q & ~f_dir_q & `MASK_F;
        f_slew_on_d    = f_slew_q & f_dir_q & `MASK_F;
        f_drive_high_d = f_drive_q & `MASK_F;
    end

    always @(posedge clk_sys_i or negedge resetn_i) begin
        if (!resetn_i) begin
            f_pullup_on_q  <= `RST_REG;
            f_slew_on_q    <= `RST_REG;
            f_drive_high_q <= `RST_REG;
        end else begin
            f_pullup_on_q  <= f_pullup_on_d;
            f_slew_on_q    <= f_slew_on_d;
            f_drive_high_q <= f_drive_high_d;
        end
    end

    // ======================================================================
    // Output drive.
    assign s_axi_awready_o     = awready_q;
    assign s_axi_wready_o      = wready_q;
    assign s_axi_bvalid_o      = bvalid_q;
    assign s_axi_bresp_o       = bresp_q;
    assign s_axi_arready_o     = arready_q;
    assign s_axi_rvalid_o      = (rd_state_q == `ST_RD_RESP);
    assign s_axi_rdata_o       = rdata_q;
    assign s_axi_rresp_o       = rresp_q;

    assign port_f_pullup_on_o  = f_pullup_on_q;
    assign port_f_slew_on_o    = f_slew_on_q;
    assign port_f_drive_high_o = f_drive_high_q;
    assign port_f_dir_o        = f_dir_q;

    assign port_g_pin_o        = g_latch_q[6:0];
    assign port_g_pin_oe_o     = g_dir_q[6:0];

endmodule // port_fg_io

`default_nettype wire

// File: sim/port_fg_io_assertions.sv
// Concurrent checks on the port F and port G register block.
`timescale 1ns/1ps
`default_nettype none
module port_fg_io_assertions (
    input wire logic        clk_sys_i,
    input wire logic        resetn_i,
    input wire logic        s_axi_awvalid_i,
    input wire logic        s_axi_awready_o,
    input wire logic        s_axi_wvalid_i,
    input wire logic        s_axi_wready_o,
    input wire logic [1:0]  s_axi_bresp_o,
    input wire logic        s_axi_bvalid_o,
    input wire logic        s_axi_bready_i,
    input wire logic        s_axi_arvalid_i,
    input wire logic        s_axi_arready_o,
    input wire logic [31:0] s_axi_rdata_o,
    input wire logic        s_axi_rvalid_o,
    input wire logic        s_axi_rready_i,
    input wire logic [7:0]  port_f_pullup_on_o,
    input wire logic [7:0]  port_f_slew_on_o,
    input wire logic [7:0]  port_f_drive_high_o,
    input wire logic [7:0]  port_f_dir_o,
    input wire logic [6:0]  port_g_pin_o,
    input wire logic [6:0]  port_g_pin_oe_o
);
    // ====
    // Helper state and properties.
    logic rst_seen_q;
    always @(posedge clk_sys_i) begin
        rst_seen_q <= !resetn_i;
    end
    default clocking cb @(posedge clk_sys_i); endclocking
    default disable iff (!resetn_i);
    chk_pullup_output: assert property ((port_f_pullup_on_o & port_f_dir_o & $past(port_f_dir_o)) == 8'h00)
        else $error("pullup on at an output pin");
    chk_slew_input: assert property ((port_f_slew_on_o & ~port_f_dir_o & ~$past(port_f_dir_o)) == 8'h00)
        else $error("slew on at an input pin");
    chk_pad_reserved: assert property (((port_f_pullup_on_o | port_f_slew_on_o | port_f_drive_high_o |
        port_f_dir_o) & 8'h8C) == 8'h00) else $error("pad control on a missing pin");
    chk_reset_quiet: assert property (disable iff (1'b0) !resetn_i && rst_seen_q |->
        port_g_pin_oe_o == 7'h00 && port_g_pin_o == 7'h00 && port_f_pullup_on_o == 8'h00)
        else $error("pins not quiet in reset");
    chk_rdata_upper: assert property (s_axi_rvalid_o |-> s_axi_rdata_o[31:8] == 24'h00_0000)
        else $error("upper read data not zero");
    chk_bresp_hold: assert property (s_axi_bvalid_o && !s_axi_bready_i |=> s_axi_bvalid_o && $stable(s_axi_bresp_o))
        else $error("write response dropped");
    chk_rdata_hold: assert property (s_axi_rvalid_o && !s_axi_rready_i |=> s_axi_rvalid_o && $stable(s_axi_rdata_o))
        else $error("read data dropped");
    chk_write_answer: assert property (s_axi_awvalid_i && s_axi_awready_o && s_axi_wvalid_i && s_axi_wready_o
        |-> ##2 s_axi_bvalid_o) else $error("write response late");
    chk_read_answer: assert property (s_axi_arvalid_i && s_axi_arready_o |=> s_axi_rvalid_o)
        else $error("read response late");
    chk_busy_refuse: assert property (s_axi_bvalid_o |-> !s_axi_awready_o && !s_axi_wready_o)
        else $error("write taken while response pending");
    cov_write: cover property (s_axi_bvalid_o && s_axi_bready_i);
    cov_read: cover property (s_axi_rvalid_o && s_axi_rready_i);
    cov_pullup: cover property (port_f_pullup_on_o != 8'h00);
endmodule // port_fg_io_assertions
bind port_fg_io port_fg_io_assertions port_fg_io_assertions_inst (.*);
`default_nettype wire

// File: sim/port_g_far_end.sv
// Model of the outside circuitry on the port G pins.
`timescale 1ns/1ps
`default_nettype none
module port_g_far_end (
    input  wire logic [6:0] pin_o,
    input  wire logic [6:0] pin_oe,
    input  wire logic [6:0] ext_level,
    output logic      [6:0] level
);
    // ====
    // Driven bits follow the block, the others follow the outside source.
    assign level = (pin_o & pin_oe) | (ext_level & ~pin_oe);
endmodule // port_g_far_end
`default_nettype wire

// File: sim/tb_top.sv
// Self-checking bench for the port F and port G register block.
`timescale 1ns/1ps
`default_nettype none
`include "port_fg_defs.vh"
module tb_top;
    // ====
    // Signals, instances and bus tasks.
    logic        clk_sys_i = 1'b0, resetn_i = 1'b0;
    logic [7:0]  s_axi_awaddr_i = 8'h00, s_axi_araddr_i = 8'h00;
    logic [2:0]  s_axi_awprot_i = 3'h0, s_axi_arprot_i = 3'h0;
    logic [31:0] s_axi_wdata_i = 32'h0, s_axi_rdata_o, rdat;
    logic [3:0]  s_axi_wstrb_i = 4'h0;
    logic        s_axi_awvalid_i = 1'b0, s_axi_wvalid_i = 1'b0, s_axi_bready_i = 1'b0;
    logic        s_axi_arvalid_i = 1'b0, s_axi_rready_i = 1'b0;
    logic        s_axi_awready_o, s_axi_wready_o, s_axi_bvalid_o, s_axi_arready_o, s_axi_rvalid_o;
    logic [1:0]  s_axi_bresp_o, s_axi_rresp_o, resp;
    logic [7:0]  port_f_pullup_on_o, port_f_slew_on_o, port_f_drive_high_o, port_f_dir_o, gd, gdir;
    logic [6:0]  port_g_pin_i, port_g_pin_o, port_g_pin_oe_o, ext_level = 7'h00;
    logic [7:0]  v [4];
    logic [7:0]  offs [4] = '{`OFS_F_PULLUP, `OFS_F_SLEW, `OFS_F_DRIVE, `OFS_F_DIR};
    int          err_count = 0, total_checks = 0, cycles = 0;
    port_fg_io port_fg_io_inst (.*);
    port_g_far_end port_g_far_end_inst (.pin_o(port_g_pin_o), .pin_oe(port_g_pin_oe_o),
                                        .ext_level(ext_level), .level(port_g_pin_i));
    always #5 clk_sys_i = ~clk_sys_i;
    task report_and_stop;
        $display("checks %0d mismatches %0d", total_checks, err_count);
        if (err_count == 0 && total_checks > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask
    always @(posedge clk_sys_i) begin
        cycles <= cycles + 1;
        if (cycles == 8000) begin
            err_count++;
            report_and_stop();
        end
    end
    task chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp) begin
            $display("ERROR %s expected %h seen %h", nm, exp, seen);
            err_count++;
        end
    endtask
    function logic [7:0] exp_g(input logic [7:0] lat, input logic [7:0] dir, input logic [6:0] ext);
        return {1'b0, (lat[6:0] & dir[6:0]) | (ext & ~dir[6:0])};
    endfunction
    task automatic wr(input logic [7:0] a, input logic [7:0] d, input logic [3:0] s);
        logic ta, tw, tb, ca, cw;
        ta = 1'b0;
        tw = 1'b0;
        tb = 1'b0;
        @(posedge clk_sys_i);
        s_axi_awaddr_i <= a;
        s_axi_wdata_i <= {24'h00_0000, d};
        s_axi_wstrb_i <= s;
        s_axi_awvalid_i <= 1'b1;
        s_axi_wvalid_i <= 1'b1;
        s_axi_bready_i <= 1'b1;
        while (!tb) begin
            @(negedge clk_sys_i);
            ca = !ta && s_axi_awready_o;
            cw = !tw && s_axi_wready_o;
            tb = s_axi_bvalid_o;
            @(posedge clk_sys_i);
            if (ca) s_axi_awvalid_i <= 1'b0;
            if (cw) s_axi_wvalid_i <= 1'b0;
            if (tb) begin
                resp = s_axi_bresp_o;
                s_axi_bready_i <= 1'b0;
            end
            ta = ta | ca;
            tw = tw | cw;
        end
    endtask
    task automatic rd(input logic [7:0] a);
        logic ta, tr, c;
        ta = 1'b0;
        tr = 1'b0;
        @(posedge clk_sys_i);
        s_axi_araddr_i <= a;
        s_axi_arvalid_i <= 1'b1;
        s_axi_rready_i <= 1'b1;
        while (!tr) begin
            @(negedge clk_sys_i);
            c = !ta && s_axi_arready_o;
            tr = s_axi_rvalid_o;
            @(posedge clk_sys_i);
            if (c) s_axi_arvalid_i <= 1'b0;
            if (tr) begin
                rdat = s_axi_rdata_o;
                resp = s_axi_rresp_o;
                s_axi_rready_i <= 1'b0;
            end
            ta = ta | c;
        end
    endtask
    task settle;
        repeat (3) @(negedge clk_sys_i);
    endtask
    initial begin
        void'($urandom(32'hD6D7));
        repeat (3) @(posedge clk_sys_i);
        resetn_i <= 1'b1;
        for (int k = 0; k < 6; k++) begin
            rd(8'(k * 4));
            chk("reset value", rdat, `RST_WORD);
        end
        rd(8'h18);
        chk("unmapped read", {30'h0, resp}, {30'h0, `RESP_SLVERR});
        wr(8'h1C, 8'hFF, 4'h1);
        chk("unmapped write", {30'h0, resp}, {30'h0, `RESP_SLVERR});
        $display("test reset_map done");
        for (int i = 0; i < 16; i++) begin
            for (int k = 0; k < 4; k++) begin
                v[k] = (i < 2) ? ((k == 3 && i == 1) ? 8'h00 : 8'hFF) : 8'($urandom);
                wr(offs[k], v[k] & `MASK_F, 4'h1);
            end
            settle();
            chk("pullup", port_f_pullup_on_o, v[0] & ~v[3] & `MASK_F);
            chk("slew", port_f_slew_on_o, v[1] & v[3] & `MASK_F);
            chk("drive", port_f_drive_high_o, v[2] & `MASK_F);
            chk("f dir", port_f_dir_o, v[3] & `MASK_F);
            rd(offs[i % 4]);
            chk("f readback", rdat, {24'h00_0000, v[i % 4] & `MASK_F});
        end
        $display("test port_f done");
        for (int i = 0; i < 12; i++) begin
            gd = (i == 0) ? 8'hFF : 8'($urandom);
            gdir = (i < 2) ? {8{i[0]}} : 8'($urandom);
            wr(`OFS_G_DIR, gdir, 4'h1);
            wr(`OFS_G_DATA, gd, 4'h1);
            ext_level <= 7'($urandom);
            settle();
            chk("g pin out", port_g_pin_o, gd[6:0]);
            chk("g oe", port_g_pin_oe_o, gdir[6:0]);
            rd(`OFS_G_DATA);
            chk("g data read", rdat, {24'h00_0000, exp_g(gd, gdir, ext_level)});
            rd(`OFS_G_DIR);
            chk("g dir read", rdat, {24'h00_0000, gdir & `MASK_G});
        end
        $display("test port_g done");
        wr(`OFS_G_DIR, 8'h00, 4'h1);
        wr(`OFS_G_DATA, 8'h55, 4'h1);
        wr(`OFS_G_DATA, 8'h2A, 4'hE);
        chk("strobe resp", {30'h0, resp}, {30'h0, `RESP_OKAY});
        wr(`OFS_G_DIR, 8'h7F, 4'h1);
        rd(`OFS_G_DATA);
        chk("latch of inputs", rdat, 32'h0000_0055);
        $display("test latch_strobe done");
        @(posedge clk_sys_i);
        resetn_i <= 1'b0;
        settle();
        chk("reset oe", port_g_pin_oe_o, 7'h00);
        @(posedge clk_sys_i);
        resetn_i <= 1'b1;
        wr(`OFS_G_DIR, 8'h7F, 4'h1);
        settle();
        chk("reset latch", port_g_pin_o, 7'h00);
        chk("reset pullup", port_f_pullup_on_o, 8'h00);
        $display("test rerun_reset done");
        report_and_stop();
    end
endmodule // tb_top
`default_nettype wire
